// file: src/clkctl_consts.svh
// Constants for the system clock enable, divide and output block.
// Assumes an 8-bit register port with offsets at their special-register
// addresses; included by the package and the design.
`ifndef CLKCTL_CONSTS_SVH
`define CLKCTL_CONSTS_SVH
// Register offsets
`define OFS_CLOCK_CONTROL 8'h8e
`define OFS_SYSTEM_CLOCK_DIVIDER 8'h95
`define OFS_CLOCK_SWITCH 8'h96
`define OFS_CLOCK_SOURCE_ENABLE 8'h97
// Reset values
`define RST_CLOCK_CONTROL 8'h00
`define RST_SYSTEM_CLOCK_DIVIDER 8'h00
`define RST_CLOCK_SOURCE_ENABLE 8'h30
`define RST_OSC_SELECT 2'h0
// Field positions
`define POS_EXT_EN_HI 7
`define POS_EXT_EN_LO 6
`define POS_FAST_OSC_EN 5
`define POS_FAULT 0
`define POS_CLOCK_OUT_EN 1
`define POS_FAST_OSC_ST 5
`define POS_EXT_ST 3
`define POS_OSC_SEL_HI 2
`define POS_OSC_SEL_LO 1
// Field values
`define EXT_EN_ON 2'h3
`endif

// file: src/clkctl_pkg.sv
// Types for the system clock enable, divide and output block.
// Assumes the constants header sits beside it on the include path.
package clkctl_pkg;
  `include "clkctl_consts.svh"

  // System clock source encodings
  typedef enum logic [1:0] {
    SRC_FAST_OSC = 2'h0,
    SRC_EXT_CLK = 2'h1,
    SRC_SLOW_OSC = 2'h2,
    SRC_RESERVED = 2'h3
  } osc_sel_t;

  // Oscillator enables and stable flags travel together
  typedef struct packed {
    logic fast_en;
    logic ext_en;
    logic slow_en;
  } src_vec_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : clkctl_pkg

// file: src/clkctl.sv
// System clock control: source enables, switch supervision, divider, output.
// Assumes the oscillators are modelled as enable/stable levels from the
// analog side; stable inputs are asynchronous and are synchronised here.
// Functional notes
// RULE1 - Enable field 11 makes the external clock input an available source.
// RULE2 - Other enable field values disable external clock; pin back to GPIO.
// RULE3 - Fast oscillator enable bit turns that oscillator off at 0, on at 1.
// RULE4 - While programming enable set, force fast oscillator on and report set.
// RULE5 - On programming enable clear, restore previous fast enable and status.
// RULE6 - Fault flag reads 0 after a successful clock source change.
// RULE7 - Fault set on unstable or disabled target; holds till switch completes.
// RULE8 - Fault flag is read-only to software, changed only by hardware.
// RULE9 - Divider zero passes the oscillator clock undivided.
// RULE10 - Divider N of 1 to 255 divides oscillator clock by 2N.
// RULE11 - Divider accepts new values any time without halting execution.
// RULE12 - Clock output carries the divided system clock; with divider zero the pin runs at half the oscillator clock.
// RULE13 - Clock output enable bit 1 gates the system clock onto the pin.
// RULE14 - Clock output stops toggling during power-down.
// RULE15 - Select 00 fast, 01 external, 10 slow oscillator; 11 reserved.
// RULE16 - Writes disabling the running source are ignored entirely.
// RULE17 - Selecting a disabled source updates select, keeps clock, sets fault.
// RULE18 - Selecting unstable enabled source waits for stable, then switches.
// RULE19 - Source and divider changes apply only at clock boundaries.
// RULE20 - Reset leaves divider zero, output off, running on fast oscillator.
//
// Local design decision: the strobed register port.
`include "clkctl_consts.svh"
module clkctl
  import clkctl_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Power and programming state
  input wire logic IN_APP_PROGRAMMING_ENABLE,
  input wire logic POWER_DOWN,
  // Oscillator stable levels from the analog side
  input wire logic FAST_OSC_READY,
  input wire logic EXT_CLK_READY,
  input wire logic SLOW_OSC_READY,
  // Oscillator enables to the analog side
  output logic FAST_INTERNAL_OSC_ENABLE,
  output logic EXT_CLK_INPUT_ENABLE,
  output logic SHARED_GPIO_PIN_FREE,
  // Clock source in use and system clock enable pulse
  output logic [1:0] ACTIVE_SOURCE,
  output logic SYS_CLK_TICK,
  // Clock output pin
  output logic CLOCK_OUT_PIN_O,
  output logic CLOCK_OUT_PIN_OE
);

  ////////////////////////////////////////////////////////////////////////
  // Stable input synchronisers: three flops, change once stages 2 and 3 agree
  logic [2:0] rdy_in;
  logic [2:0] s1_q, s2_q, s3_q, rdy_q;
  logic [2:0] s1_d, s2_d, s3_d, rdy_d;
  assign rdy_in = {FAST_OSC_READY, EXT_CLK_READY, SLOW_OSC_READY};

  // Per-source filter, same for every bit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_comb begin
        s1_d[gi] = rdy_in[gi];
        s2_d[gi] = s1_q[gi];
        s3_d[gi] = s2_q[gi];
        rdy_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : rdy_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      rdy_q <= 3'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      rdy_q <= rdy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg_req_t req;
  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  logic [1:0] ext_en_q, ext_en_d;
  logic fast_en_q, fast_en_d;       // Software view, kept while forced
  logic fault_q, fault_d;
  logic clk_out_en_q, clk_out_en_d;
  logic [7:0] divisor_q, divisor_d;
  osc_sel_t sel_q, sel_d;           // Software select field
  osc_sel_t act_q, act_d;           // Source actually running
  logic pend_q, pend_d;             // Waiting for target to stabilise
  logic [7:0] rdata_q, rdata_d;

  src_vec_t en_eff;
  src_vec_t st_eff;
  logic ext_on;
  logic fast_on;
  logic [7:0] enable_read;
  logic [7:0] switch_read;
  logic boundary;
  logic target_en;
  logic target_st;

  // RULE1 enable field 11
  // RULE2 other values disable
  assign ext_on = (ext_en_q == `EXT_EN_ON);
  // RULE4 forced on
  // RULE3 enable bit drives
  assign fast_on = fast_en_q | IN_APP_PROGRAMMING_ENABLE;
  assign en_eff = '{fast_en: fast_on, ext_en: ext_on, slow_en: 1'b1};
  // Stable only counts while the source is enabled
  assign st_eff = '{fast_en: IN_APP_PROGRAMMING_ENABLE |
                             (fast_on & rdy_q[2]),
                    ext_en: ext_on & rdy_q[1],
                    slow_en: rdy_q[0]};

  // RULE15 source decode
  function automatic logic pick(input src_vec_t v, input osc_sel_t s);
    case (s)
      SRC_FAST_OSC: pick = v.fast_en;
      SRC_EXT_CLK: pick = v.ext_en;
      SRC_SLOW_OSC: pick = v.slow_en;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  assign target_en = pick(en_eff, sel_q);
  assign target_st = pick(st_eff, sel_q);

  // Read views; select field is write only and reads back zero
  always_comb begin
    enable_read = 8'h00;
    enable_read[`POS_EXT_EN_HI:`POS_EXT_EN_LO] = ext_en_q;
    // RULE5 restored view
    enable_read[`POS_FAST_OSC_EN] = fast_on;
    enable_read[`POS_FAULT] = fault_q;
    switch_read = 8'h00;
    switch_read[`POS_FAST_OSC_ST] = st_eff.fast_en;
    switch_read[`POS_EXT_ST] = st_eff.ext_en;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes, switch supervision and read data
  always_comb begin
    ext_en_d = ext_en_q;
    fast_en_d = fast_en_q;
    fault_d = fault_q;
    clk_out_en_d = clk_out_en_q;
    divisor_d = divisor_q;
    sel_d = sel_q;
    act_d = act_q;
    pend_d = pend_q;
    rdata_d = 8'h00;
    if (req.wr) begin
      case (req.addr)
        `OFS_CLOCK_SOURCE_ENABLE: begin
          // RULE16 keep running source
          // Refused even while forced on, or it would drop when forcing ends
          if (!((act_q == SRC_EXT_CLK) &&
                (req.wdata[`POS_EXT_EN_HI:`POS_EXT_EN_LO] != `EXT_EN_ON)) &&
              !((act_q == SRC_FAST_OSC) &&
                !req.wdata[`POS_FAST_OSC_EN])) begin
            ext_en_d = req.wdata[`POS_EXT_EN_HI:`POS_EXT_EN_LO];
            // RULE8 fault not writable
            fast_en_d = req.wdata[`POS_FAST_OSC_EN];
          end
        end
        `OFS_CLOCK_SWITCH: begin
          sel_d = osc_sel_t'(req.wdata[`POS_OSC_SEL_HI:`POS_OSC_SEL_LO]);
          // RULE17 select updates now
          pend_d = 1'b1;
        end
        `OFS_SYSTEM_CLOCK_DIVIDER: begin
          // RULE11 write any time
          divisor_d = req.wdata;
        end
        `OFS_CLOCK_CONTROL: begin
          clk_out_en_d = req.wdata[`POS_CLOCK_OUT_EN];
        end
        default: begin
        end
      endcase
    end
    // Pending switch is resolved against the current select field
    if (pend_q) begin
      if (!target_en) begin
        // RULE17 disabled target faults
        fault_d = 1'b1;
        pend_d = 1'b0;
      end else if (!target_st) begin
        // RULE7 unstable target faults
        fault_d = 1'b1;
      end else if (boundary) begin
        // RULE18 switch in background
        // RULE19 at boundary only
        act_d = sel_q;
        // RULE6 success clears
        fault_d = 1'b0;
        pend_d = 1'b0;
      end
      if (req.wr && (req.addr == `OFS_CLOCK_SWITCH)) begin
        pend_d = 1'b1;
      end
    end
    if (req.rd) begin
      case (req.addr)
        `OFS_CLOCK_SOURCE_ENABLE: rdata_d = enable_read;
        `OFS_CLOCK_SWITCH: rdata_d = switch_read;
        `OFS_SYSTEM_CLOCK_DIVIDER: rdata_d = divisor_q;
        `OFS_CLOCK_CONTROL: rdata_d = {6'h00, clk_out_en_q, 1'b0};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // RULE20 reset state
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ext_en_q <= 2'(`RST_CLOCK_SOURCE_ENABLE >> `POS_EXT_EN_LO);
      fast_en_q <= 1'b1;
      fault_q <= 1'b0;
      clk_out_en_q <= 1'b0;
      divisor_q <= `RST_SYSTEM_CLOCK_DIVIDER;
      sel_q <= SRC_FAST_OSC;
      act_q <= SRC_FAST_OSC;
      pend_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ext_en_q <= ext_en_d;
      fast_en_q <= fast_en_d;
      fault_q <= fault_d;
      clk_out_en_q <= clk_out_en_d;
      divisor_q <= divisor_d;
      sel_q <= sel_d;
      act_q <= act_d;
      pend_q <= pend_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider: system clock as a phase toggling every divisor cycles
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] div_live_q, div_live_d;  // Divisor in force this period
  logic phase_q, phase_d;
  logic tick_q, tick_d;
  logic co_q, co_d;

  // A boundary is the end of a full high phase, or every cycle undivided
  assign boundary = (div_live_q == 8'h00) ||
                    (phase_q && (cnt_q == div_live_q - 8'h01));

  always_comb begin
    cnt_d = cnt_q;
    div_live_d = div_live_q;
    phase_d = phase_q;
    tick_d = 1'b0;
    if (POWER_DOWN) begin
      // RULE14 halted in power-down
      cnt_d = cnt_q;
    end else if (div_live_q == 8'h00) begin
      // RULE9 undivided
      tick_d = 1'b1;
      phase_d = ~phase_q;
      div_live_d = divisor_q;
      cnt_d = 8'h00;
    end else if (cnt_q == div_live_q - 8'h01) begin
      // RULE10 half period of N
      cnt_d = 8'h00;
      phase_d = ~phase_q;
      if (phase_q) begin
        tick_d = 1'b1;
        // RULE19 new divisor per period
        div_live_d = divisor_q;
      end
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
    // RULE13 output gate
    // RULE12 divided clock out
    // Next enable, so the pin never outlives its enable by a cycle
    co_d = clk_out_en_d & phase_d;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cnt_q <= 8'h00;
      div_live_q <= 8'h00;
      phase_q <= 1'b0;
      tick_q <= 1'b0;
      co_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_live_q <= div_live_d;
      phase_q <= phase_d;
      tick_q <= tick_d;
      co_q <= co_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign REG_RDATA = rdata_q;
  assign FAST_INTERNAL_OSC_ENABLE = fast_on;
  assign EXT_CLK_INPUT_ENABLE = ext_on;
  assign SHARED_GPIO_PIN_FREE = ~ext_on;
  assign ACTIVE_SOURCE = act_q;
  assign SYS_CLK_TICK = tick_q;
  assign CLOCK_OUT_PIN_O = co_q;
  assign CLOCK_OUT_PIN_OE = clk_out_en_q;

endmodule : clkctl

// file: verification/clkctl_props.sv
// Checker for the clock control block, watching its top ports only.
// Assumes one clock domain and a synchronous active-high reset.
module clkctl_props
  import clkctl_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Power and oscillator state
  input wire logic IN_APP_PROGRAMMING_ENABLE,
  input wire logic POWER_DOWN,
  input wire logic EXT_CLK_READY,
  input wire logic FAST_INTERNAL_OSC_ENABLE,
  input wire logic EXT_CLK_INPUT_ENABLE,
  input wire logic SHARED_GPIO_PIN_FREE,
  // Clock in use and clock output
  input wire logic [1:0] ACTIVE_SOURCE,
  input wire logic SYS_CLK_TICK,
  input wire logic CLOCK_OUT_PIN_O,
  input wire logic CLOCK_OUT_PIN_OE
);
  // Write decodes; wr_en is shared by two properties
  logic wr_ctrl;
  logic wr_en;
  assign wr_ctrl = REG_WR && REG_ADDR == 8'h8e && REG_WDATA[1];
  assign wr_en = REG_WR && REG_ADDR == 8'h97;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  ////////////////////////////////////////////////////////////////////////
  chk_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data not zero outside its slot");
  chk_gpio_inverse: assert property (
    SHARED_GPIO_PIN_FREE != EXT_CLK_INPUT_ENABLE)
    else $error("pin release does not mirror ext enable");
  chk_ext_by_write: assert property (
    $changed(EXT_CLK_INPUT_ENABLE) |-> $past(wr_en))
    else $error("ext enable moved without a write");
  chk_iap_force: assert property (
    IN_APP_PROGRAMMING_ENABLE |-> FAST_INTERNAL_OSC_ENABLE)
    else $error("fast osc not forced on");
  chk_fast_off: assert property (
    $fell(FAST_INTERNAL_OSC_ENABLE) |-> ACTIVE_SOURCE != SRC_FAST_OSC &&
    ($fell(IN_APP_PROGRAMMING_ENABLE) || $past(wr_en && !REG_WDATA[5])))
    else $error("fast osc dropped while running or unasked");
  chk_oe_gate: assert property (
    !CLOCK_OUT_PIN_OE |-> !CLOCK_OUT_PIN_O)
    else $error("clock out active while disabled");
  chk_oe_rise: assert property (
    $rose(CLOCK_OUT_PIN_OE) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("clock out enabled without a write");
  chk_pd_freeze: assert property (
    POWER_DOWN [*3] |-> !SYS_CLK_TICK && $stable(CLOCK_OUT_PIN_O))
    else $error("clock still running in power down");
  chk_src_legal: assert property (
    ACTIVE_SOURCE != SRC_RESERVED)
    else $error("reserved source in use");
  chk_ext_ready: assert property (
    $changed(ACTIVE_SOURCE) && ACTIVE_SOURCE == SRC_EXT_CLK |->
    $past(EXT_CLK_READY, 3) && EXT_CLK_INPUT_ENABLE)
    else $error("switched to ext before it was stable");
  chk_reset_state: assert property (
    $fell(SYS_RST) |-> FAST_INTERNAL_OSC_ENABLE && !CLOCK_OUT_PIN_OE &&
    ACTIVE_SOURCE == SRC_FAST_OSC && !EXT_CLK_INPUT_ENABLE)
    else $error("wrong state after reset");

  // Main scenarios reached
  cover property (ACTIVE_SOURCE == SRC_EXT_CLK && CLOCK_OUT_PIN_OE);
  cover property (ACTIVE_SOURCE == SRC_SLOW_OSC && IN_APP_PROGRAMMING_ENABLE);
  cover property (POWER_DOWN [*3]);
endmodule : clkctl_props

bind clkctl clkctl_props props_i (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .POWER_DOWN(POWER_DOWN),
  .IN_APP_PROGRAMMING_ENABLE(IN_APP_PROGRAMMING_ENABLE),
  .EXT_CLK_READY(EXT_CLK_READY), .ACTIVE_SOURCE(ACTIVE_SOURCE),
  .FAST_INTERNAL_OSC_ENABLE(FAST_INTERNAL_OSC_ENABLE),
  .EXT_CLK_INPUT_ENABLE(EXT_CLK_INPUT_ENABLE),
  .SHARED_GPIO_PIN_FREE(SHARED_GPIO_PIN_FREE),
  .SYS_CLK_TICK(SYS_CLK_TICK), .CLOCK_OUT_PIN_O(CLOCK_OUT_PIN_O),
  .CLOCK_OUT_PIN_OE(CLOCK_OUT_PIN_OE)
);

// file: verification/clkctl_tb_top.sv
// Self-checking bench for the clock control block.
// Assumes oscillator ready levels are plain levels driven from here.
module clkctl_tb_top
  import clkctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string name; logic [7:0] exp; logic [7:0] mask;} note_t;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, iap = 1'b0, pd = 1'b0;
  logic f_rdy = 1'b1, e_rdy = 1'b0, s_rdy = 1'b1, rd_d, clk_o_q;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic fast_en, ext_en, gpio_free, tick, clk_o, clk_oe;
  logic [1:0] src;
  int miscompares = 0, tests_run = 0, cyc = 0;
  note_t notes[$];
  note_t n;

  clkctl DUT (
    .SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .POWER_DOWN(pd),
    .IN_APP_PROGRAMMING_ENABLE(iap), .FAST_OSC_READY(f_rdy),
    .EXT_CLK_READY(e_rdy), .SLOW_OSC_READY(s_rdy),
    .FAST_INTERNAL_OSC_ENABLE(fast_en), .EXT_CLK_INPUT_ENABLE(ext_en),
    .SHARED_GPIO_PIN_FREE(gpio_free), .ACTIVE_SOURCE(src),
    .SYS_CLK_TICK(tick), .CLOCK_OUT_PIN_O(clk_o), .CLOCK_OUT_PIN_OE(clk_oe)
  );

  // 50 MHz system clock
  initial forever #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic check_bit(string nm, logic e, logic g);
    check(nm, {7'h0, e}, {7'h0, g});
  endtask : check_bit

  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(string nm, logic [7:0] a, logic [7:0] e,
                        logic [7:0] m = 8'hff);
    notes.push_back('{nm, e, m});
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg

  task automatic wait_src(logic [1:0] s);
    for (int i = 0; i < 300 && src !== s; i++) @(posedge clk);
    check("active_source", {6'h0, s}, {6'h0, src});
  endtask : wait_src

  // Third count is a whole period; the first two absorb the boundary
  task automatic measure(string nm, bit co, int e);
    int c;
    for (int k = 0; k < 3; k++) begin
      c = 0;
      do begin
        @(posedge clk);
        c++;
      end while (!(co ? clk_o && !clk_o_q : tick) && c < 1100);
    end
    check(nm, 8'(e), 8'(c));
  endtask : measure

  // Read results leave the queue in order; hang guard
  always @(posedge clk) begin
    rd_d <= rd;
    clk_o_q <= clk_o;
    cyc <= cyc + 1;
    if (rd_d && notes.size() > 0) begin
      n = notes.pop_front();
      check(n.name, n.exp & n.mask, rdata & n.mask);
    end
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] nv[5];
    logic co;
    void'($urandom(32'hf279d5dc));
    nv = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h00};
    nv[4] = 8'($urandom_range(20, 3));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg("ctrl", 8'h8e, 8'h00);
    rd_reg("divider", 8'h95, 8'h00);
    rd_reg("enable", 8'h97, 8'h20, 8'he1);
    rd_reg("unmapped", 8'h90, 8'h00);
    // Every enable field code, each with the fault bit written high
    for (int v = 0; v < 4; v++) begin
      wr_reg(8'h97, {2'(v), 6'h21});
      check_bit("ext_en", v == 3, ext_en);
      check_bit("gpio_free", v != 3, gpio_free);
      rd_reg("enable", 8'h97, {2'(v), 6'h20}, 8'he1);
    end
    wr_reg(8'h97, 8'h00);
    rd_reg("enable", 8'h97, 8'he0, 8'he1);
    wr_reg(8'h97, 8'h20);
    wr_reg(8'h96, 8'h02);
    repeat (3) @(posedge clk);
    rd_reg("fault", 8'h97, 8'h21, 8'he1);
    check_bit("on_fast", 1'b1, src === SRC_FAST_OSC);
    wr_reg(8'h97, 8'he0);
    wr_reg(8'h96, 8'h02);
    repeat (8) @(posedge clk);
    rd_reg("fault", 8'h97, 8'he1, 8'he1);
    check_bit("on_fast", 1'b1, src === SRC_FAST_OSC);
    e_rdy <= 1'b1;
    wait_src(SRC_EXT_CLK);
    rd_reg("fault", 8'h97, 8'he0, 8'he1);
    rd_reg("status", 8'h96, 8'h28, 8'h28);
    wr_reg(8'h8e, 8'h02);
    @(posedge clk);
    check_bit("clk_oe", 1'b1, clk_oe);
    foreach (nv[i]) begin
      wr_reg(8'h95, nv[i]);
      rd_reg("divider", 8'h95, nv[i]);
      measure("tick_period", 0, nv[i] == 0 ? 1 : 2 * nv[i]);
      measure("clk_out_period", 1, nv[i] == 0 ? 2 : 2 * nv[i]);
    end
    pd <= 1'b1;
    repeat (4) @(posedge clk);
    co = clk_o;
    repeat (20) begin
      @(posedge clk);
      check_bit("pd_clk_out", co, clk_o);
    end
    pd <= 1'b0;
    wr_reg(8'h96, 8'h06);
    rd_reg("fault", 8'h97, 8'he1, 8'he1);
    check_bit("on_ext", 1'b1, src === SRC_EXT_CLK);
    wr_reg(8'h96, 8'h04);
    wait_src(SRC_SLOW_OSC);
    wr_reg(8'h97, 8'h00);
    check_bit("fast_en", 1'b0, fast_en);
    iap <= 1'b1;
    @(posedge clk);
    check_bit("fast_en", 1'b1, fast_en);
    rd_reg("enable", 8'h97, 8'h20, 8'he1);
    rd_reg("status", 8'h96, 8'h20, 8'h20);
    iap <= 1'b0;
    @(posedge clk);
    check_bit("fast_en", 1'b0, fast_en);
    rd_reg("enable", 8'h97, 8'h00, 8'he1);
    rd_reg("status", 8'h96, 8'h00, 8'h20);
    summarize();
  end
endmodule : clkctl_tb_top
